// ===== rtl/emalu_pkg.sv
// Shared constants and types for the far memory ALU block
package emalu_pkg;

  // ----------
  // Widths
  // ----------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int WB_AW  = 8;
  localparam int BIT_W  = 3;

  // ----------
  // Register byte offsets
  // ----------
  localparam logic [WB_AW-1:0] CMD_OFF    = 8'h00;
  localparam logic [WB_AW-1:0] ADDR_OFF   = 8'h04;
  localparam logic [WB_AW-1:0] WORK_OFF   = 8'h08;
  localparam logic [WB_AW-1:0] FLAGS_OFF  = 8'h0C;
  localparam logic [WB_AW-1:0] STATUS_OFF = 8'h10;

  // ----------
  // Field positions
  // ----------
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_BIT_LSB = 8;
  localparam int FLAG_C      = 0;
  localparam int FLAG_AC     = 1;
  localparam int FLAG_Z      = 2;
  localparam int FLAG_OV     = 3;
  localparam int FLAG_SC     = 4;
  localparam int FLAG_CZ     = 5;
  localparam int FLAG_W      = 6;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_SKIP   = 1;

  // ----------
  // Reset values and cycle counts
  // ----------
  localparam logic [DATA_W-1:0] WORK_RST  = 8'h00;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 12'h000;
  localparam int SKIP_CYCLES  = 3;
  localparam int PLAIN_CYCLES = 2;

  // ----------
  // Operations
  // ----------
  typedef enum logic [4:0] {
    OP_FAR_INCREMENT_TO_WORK      = 5'h00,
    OP_FAR_MOVE_TO_WORK           = 5'h01,
    OP_FAR_MOVE_TO_MEMORY         = 5'h02,
    OP_FAR_OR_TO_WORK             = 5'h03,
    OP_FAR_OR_TO_MEMORY           = 5'h04,
    OP_FAR_ROTATE_LEFT            = 5'h05,
    OP_FAR_ROTATE_LEFT_TO_WORK    = 5'h06,
    OP_FAR_ROTATE_LEFT_CARRY      = 5'h07,
    OP_FAR_ROTATE_LEFT_CARRY_TO_WORK  = 5'h08,
    OP_FAR_ROTATE_RIGHT           = 5'h09,
    OP_FAR_ROTATE_RIGHT_TO_WORK   = 5'h0A,
    OP_FAR_ROTATE_RIGHT_CARRY     = 5'h0B,
    OP_FAR_ROTATE_RIGHT_CARRY_TO_WORK = 5'h0C,
    OP_FAR_SUBTRACT_BORROW        = 5'h0D,
    OP_FAR_SUBTRACT_BORROW_TO_MEMORY  = 5'h0E,
    OP_FAR_SUBTRACT               = 5'h0F,
    OP_FAR_SUBTRACT_TO_MEMORY     = 5'h10,
    OP_FAR_DECREMENT_SKIP         = 5'h11,
    OP_FAR_DECREMENT_SKIP_TO_WORK = 5'h12,
    OP_FAR_INCREMENT_SKIP         = 5'h13,
    OP_FAR_INCREMENT_SKIP_TO_WORK = 5'h14,
    OP_FAR_FILL_ONES              = 5'h15,
    OP_FAR_SET_BIT                = 5'h16,
    OP_FAR_BIT_SKIP               = 5'h17,
    OP_FAR_NONZERO_SKIP           = 5'h18
  } emalu_op_type;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_EXEC  = 4'b0100,
    ST_DUMMY = 4'b1000
  } emalu_state_type;

endpackage

// ===== rtl/emalu_sub.sv
// Eight-bit subtractor with the arithmetic status outputs
`timescale 1ns/1ps
module emalu_sub (
  // Operands
  input  wire logic [7:0] minuend_i,
  input  wire logic [7:0] subtrahend_i,
  input  wire logic       carry_i,
  // Result and flags
  output logic      [7:0] diff_o,
  output logic            carry_o,
  output logic            half_o,
  output logic            wrap_o
);

  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // Borrow is the inverted carry: a - b - ~c is a + ~b + c
  assign full_sum = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + {8'h00, carry_i};
  assign low_sum  = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]} + {4'h0, carry_i};
  assign diff_o   = full_sum[7:0];
  assign carry_o  = full_sum[8];
  assign half_o   = low_sum[4];
  assign wrap_o   = (minuend_i[7] ^ subtrahend_i[7]) & (minuend_i[7] ^ full_sum[7]);

endmodule

// ===== rtl/emalu_top.sv
// Far data memory ALU datapath with a classic Wishbone register slave
//
// What this block does
// - Operand address is full width, reaching any memory section without banking.
// - Increment-to-work puts memory plus one in work; only zero flag.
// - Moves copy memory to work or work to memory; no flags.
// - OR of work and memory to work or memory; only zero flag.
// - Rotate left, bit 7 into bit 0, to memory or work; no flags.
// - Rotate left through carry, old carry in, bit 7 out; only carry.
// - Rotate right, bit 0 into bit 7, to memory or work; no flags.
// - Rotate right through carry, old carry into bit 7; only carry.
// - Subtract memory and inverted carry from work; six flags updated.
// - Subtract memory from work to work or memory; six flags updated.
// - Subtraction carry is 0 when negative, 1 when zero or positive.
// - Decrement memory, write back, skip next when result zero; no flags.
// - Increment memory, write back, skip next when result zero; no flags.
// - Work variants write only work; skip judged on that value.
// - Skip instructions take three cycles; otherwise continue normally.
// - Fill writes all ones; bit form sets only selected bit; no flags.
// - Bit test skips when selected memory bit is one; no flags.
// - Byte test rewrites memory and skips when nonzero; no flags.
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module emalu_top
  import emalu_pkg::*;
(
  // Clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          nrst_i,
  // Wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [emalu_pkg::WB_AW-1:0]   wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  // Data memory port
  output logic      [emalu_pkg::ADDR_W-1:0]  mem_addr_o,
  output logic                               mem_rd_o,
  input  wire logic [emalu_pkg::DATA_W-1:0]  mem_rdata_i,
  output logic                               mem_we_o,
  output logic      [emalu_pkg::DATA_W-1:0]  mem_wdata_o,
  // Sequencer status
  output logic                               busy_o,
  output logic                               skip_o,
  output logic                               done_o
);

  import emalu_pkg::*;

  // ----------
  // Declarations
  // ----------
  emalu_state_type     state_reg, state_next;
  emalu_op_type        op_reg;
  logic [BIT_W-1:0]    bit_reg;
  logic [ADDR_W-1:0]   addr_reg;
  logic [DATA_W-1:0]   work_reg, mem_wdata_reg, opnd, result, sub_diff, bit_mask;
  logic [FLAG_W-1:0]   flags_reg;
  logic [31:0]         rdata_reg;
  logic                skip_reg, skip_pend_reg, done_reg, ack_reg, mem_we_reg;
  logic                wb_req, wb_wr, start, to_work, to_mem, upd_z, upd_c, upd_arith;
  logic                chain, new_c, is_skip, take_skip, sub_borrow_in, sub_c, sub_ac;
  logic                sub_ov, sub_z, cur_c;

  // ----------
  // Wishbone slave
  // ----------
  assign wb_req   = wb_cyc_i & wb_stb_i;
  // Write lands on the edge where the master sees ack
  assign wb_wr    = wb_req & wb_we_i & ack_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req & ~ack_reg;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (wb_req & ~ack_reg) begin
      if (wb_adr_i == CMD_OFF) begin
        rdata_reg <= {21'h00_0000, bit_reg, 3'h0, op_reg};
      end else if (wb_adr_i == ADDR_OFF) begin
        rdata_reg <= {20'h0_0000, addr_reg};
      end else if (wb_adr_i == WORK_OFF) begin
        rdata_reg <= {24'h00_0000, work_reg};
      end else if (wb_adr_i == FLAGS_OFF) begin
        rdata_reg <= {26'h000_0000, flags_reg};
      end else if (wb_adr_i == STATUS_OFF) begin
        rdata_reg <= {30'h0000_0000, skip_reg, busy_o};
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end
  end

  // Command write starts an operation; ignored while one is running
  assign start = wb_wr & (wb_adr_i == CMD_OFF) & wb_sel_i[0] & (state_reg == ST_IDLE);

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_reg  <= OP_FAR_MOVE_TO_WORK;
      bit_reg <= '0;
    end else if (start) begin
      op_reg <= emalu_op_type'(wb_dat_i[CMD_OP_LSB +: 5]);
      if (wb_sel_i[1]) begin
        bit_reg <= wb_dat_i[CMD_BIT_LSB +: BIT_W];
      end
    end
  end

  // Full-width address, no bank register involved
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_reg <= ADDR_RST;
    end else if (wb_wr & (wb_adr_i == ADDR_OFF) & (state_reg == ST_IDLE)) begin
      if (wb_sel_i[0]) begin
        addr_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        addr_reg[ADDR_W-1:8] <= wb_dat_i[ADDR_W-1:8];
      end
    end
  end

  // ----------
  // Sequencer
  // ----------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_FETCH;
        end
      end
      ST_FETCH: begin
        state_next = ST_EXEC;
      end
      ST_EXEC: begin
        // Skip forms spend one more cycle on the dummy slot
        state_next = is_skip ? ST_DUMMY : ST_IDLE;
      end
      ST_DUMMY: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy_o     = (state_reg != ST_IDLE);
  assign mem_rd_o   = (state_reg == ST_FETCH);
  assign mem_addr_o = addr_reg;
  assign mem_we_o   = mem_we_reg;
  assign mem_wdata_o = mem_wdata_reg;
  assign skip_o     = skip_reg;
  assign done_o     = done_reg;

  // ----------
  // Datapath
  // ----------
  assign opnd          = mem_rdata_i;
  assign cur_c         = flags_reg[FLAG_C];
  assign bit_mask      = 8'h01 << bit_reg;
  assign sub_borrow_in = (op_reg == OP_FAR_SUBTRACT_BORROW) |
                         (op_reg == OP_FAR_SUBTRACT_BORROW_TO_MEMORY) ? cur_c : 1'b1;

  emalu_sub u_sub (
    .minuend_i    (work_reg),
    .subtrahend_i (opnd),
    .carry_i      (sub_borrow_in),
    .diff_o       (sub_diff),
    .carry_o      (sub_c),
    .half_o       (sub_ac),
    .wrap_o       (sub_ov)
  );

  assign sub_z = (sub_diff == 8'h00);

  always_comb begin
    result    = opnd;
    to_work   = 1'b0;
    to_mem    = 1'b0;
    upd_z     = 1'b0;
    upd_c     = 1'b0;
    upd_arith = 1'b0;
    chain     = 1'b0;
    new_c     = cur_c;
    is_skip   = 1'b0;
    take_skip = 1'b0;
    case (op_reg)
      OP_FAR_INCREMENT_TO_WORK: begin
        result  = opnd + 8'h01;
        to_work = 1'b1;
        upd_z   = 1'b1;
      end
      OP_FAR_MOVE_TO_WORK: begin
        to_work = 1'b1;
      end
      OP_FAR_MOVE_TO_MEMORY: begin
        result = work_reg;
        to_mem = 1'b1;
      end
      OP_FAR_OR_TO_WORK, OP_FAR_OR_TO_MEMORY: begin
        result  = work_reg | opnd;
        to_work = (op_reg == OP_FAR_OR_TO_WORK);
        to_mem  = (op_reg == OP_FAR_OR_TO_MEMORY);
        upd_z   = 1'b1;
      end
      OP_FAR_ROTATE_LEFT, OP_FAR_ROTATE_LEFT_TO_WORK: begin
        result  = {opnd[6:0], opnd[7]};
        to_work = (op_reg == OP_FAR_ROTATE_LEFT_TO_WORK);
        to_mem  = (op_reg == OP_FAR_ROTATE_LEFT);
      end
      OP_FAR_ROTATE_LEFT_CARRY, OP_FAR_ROTATE_LEFT_CARRY_TO_WORK: begin
        result  = {opnd[6:0], cur_c};
        new_c   = opnd[7];
        upd_c   = 1'b1;
        to_work = (op_reg == OP_FAR_ROTATE_LEFT_CARRY_TO_WORK);
        to_mem  = (op_reg == OP_FAR_ROTATE_LEFT_CARRY);
      end
      OP_FAR_ROTATE_RIGHT, OP_FAR_ROTATE_RIGHT_TO_WORK: begin
        result  = {opnd[0], opnd[7:1]};
        to_work = (op_reg == OP_FAR_ROTATE_RIGHT_TO_WORK);
        to_mem  = (op_reg == OP_FAR_ROTATE_RIGHT);
      end
      OP_FAR_ROTATE_RIGHT_CARRY, OP_FAR_ROTATE_RIGHT_CARRY_TO_WORK: begin
        result  = {cur_c, opnd[7:1]};
        new_c   = opnd[0];
        upd_c   = 1'b1;
        to_work = (op_reg == OP_FAR_ROTATE_RIGHT_CARRY_TO_WORK);
        to_mem  = (op_reg == OP_FAR_ROTATE_RIGHT_CARRY);
      end
      OP_FAR_SUBTRACT_BORROW, OP_FAR_SUBTRACT_BORROW_TO_MEMORY: begin
        result    = sub_diff;
        upd_arith = 1'b1;
        chain     = 1'b1;
        to_work   = (op_reg == OP_FAR_SUBTRACT_BORROW);
        to_mem    = (op_reg == OP_FAR_SUBTRACT_BORROW_TO_MEMORY);
      end
      OP_FAR_SUBTRACT, OP_FAR_SUBTRACT_TO_MEMORY: begin
        result    = sub_diff;
        upd_arith = 1'b1;
        to_work   = (op_reg == OP_FAR_SUBTRACT);
        to_mem    = (op_reg == OP_FAR_SUBTRACT_TO_MEMORY);
      end
      OP_FAR_DECREMENT_SKIP, OP_FAR_DECREMENT_SKIP_TO_WORK: begin
        result    = opnd - 8'h01;
        is_skip   = 1'b1;
        take_skip = (result == 8'h00);
        to_work   = (op_reg == OP_FAR_DECREMENT_SKIP_TO_WORK);
        to_mem    = (op_reg == OP_FAR_DECREMENT_SKIP);
      end
      OP_FAR_INCREMENT_SKIP, OP_FAR_INCREMENT_SKIP_TO_WORK: begin
        result    = opnd + 8'h01;
        is_skip   = 1'b1;
        take_skip = (result == 8'h00);
        to_work   = (op_reg == OP_FAR_INCREMENT_SKIP_TO_WORK);
        to_mem    = (op_reg == OP_FAR_INCREMENT_SKIP);
      end
      OP_FAR_FILL_ONES: begin
        result = 8'hFF;
        to_mem = 1'b1;
      end
      OP_FAR_SET_BIT: begin
        result = opnd | bit_mask;
        to_mem = 1'b1;
      end
      OP_FAR_BIT_SKIP: begin
        is_skip   = 1'b1;
        take_skip = |(opnd & bit_mask);
      end
      OP_FAR_NONZERO_SKIP: begin
        // Same byte goes back out, so side effects of a write still occur
        to_mem    = 1'b1;
        is_skip   = 1'b1;
        take_skip = (opnd != 8'h00);
      end
      default: begin
        result = opnd;
      end
    endcase
  end

  // ----------
  // Work register, flags and memory write
  // ----------
  // Software writes lose to a running operation, never collide with it
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      work_reg <= WORK_RST;
    end else if (state_reg == ST_EXEC) begin
      if (to_work) begin
        work_reg <= result;
      end
    end else if (wb_wr & (wb_adr_i == WORK_OFF) & wb_sel_i[0] & ~busy_o) begin
      work_reg <= wb_dat_i[DATA_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_reg <= FLAGS_RST;
    end else if (state_reg == ST_EXEC) begin
      // Unlisted flags are simply not assigned
      if (upd_z) begin
        flags_reg[FLAG_Z] <= (result == 8'h00);
      end
      if (upd_c) begin
        flags_reg[FLAG_C] <= new_c;
      end
      if (upd_arith) begin
        flags_reg[FLAG_C]  <= sub_c;
        flags_reg[FLAG_AC] <= sub_ac;
        flags_reg[FLAG_Z]  <= sub_z;
        flags_reg[FLAG_OV] <= sub_ov;
        flags_reg[FLAG_SC] <= ~(sub_ov ^ sub_diff[7]);
        flags_reg[FLAG_CZ] <= chain ? (sub_z & flags_reg[FLAG_CZ]) : sub_z;
      end
    end else if (wb_wr & (wb_adr_i == FLAGS_OFF) & wb_sel_i[0] & ~busy_o) begin
      flags_reg <= wb_dat_i[FLAG_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_we_reg    <= 1'b0;
      mem_wdata_reg <= 8'h00;
    end else begin
      mem_we_reg <= (state_reg == ST_EXEC) & to_mem;
      if ((state_reg == ST_EXEC) & to_mem) begin
        mem_wdata_reg <= result;
      end
    end
  end

  // ----------
  // Skip and completion reporting
  // ----------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      skip_pend_reg <= 1'b0;
      skip_reg      <= 1'b0;
      done_reg      <= 1'b0;
    end else begin
      if (state_reg == ST_EXEC) begin
        skip_pend_reg <= take_skip;
      end
      // Skip result reported with the final cycle, failing skips just finish
      if (start) begin
        skip_reg <= 1'b0;
      end else if (state_reg == ST_DUMMY) begin
        skip_reg <= skip_pend_reg;
      end
      done_reg <= (state_next == ST_IDLE) & busy_o;
    end
  end

endmodule

// ===== tb/emalu_top_sva.sv
// Property checker for the far memory ALU block
`timescale 1ns/1ps
module emalu_top_sva
  import emalu_pkg::*;
(
  // Clock and reset
  input wire logic                        sys_clk_i,
  input wire logic                        nrst_i,
  // Wishbone slave
  input wire logic                        wb_cyc_i,
  input wire logic                        wb_stb_i,
  input wire logic                        wb_we_i,
  input wire logic [emalu_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0]                  wb_sel_i,
  input wire logic [31:0]                 wb_dat_i,
  input wire logic [31:0]                 wb_dat_o,
  input wire logic                        wb_ack_o,
  // Data memory port
  input wire logic [emalu_pkg::ADDR_W-1:0] mem_addr_o,
  input wire logic                         mem_rd_o,
  input wire logic [emalu_pkg::DATA_W-1:0] mem_rdata_i,
  input wire logic                         mem_we_o,
  input wire logic [emalu_pkg::DATA_W-1:0] mem_wdata_o,
  // Sequencer status
  input wire logic                        busy_o,
  input wire logic                        skip_o,
  input wire logic                        done_o
);
  logic [4:0] op_q;
  logic       skip_op;
  logic       work_op;

  // Opcode as accepted by the slave, for gating the properties
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_q <= 5'h01;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && !busy_o
                 && wb_adr_i == CMD_OFF) begin
      op_q <= wb_dat_i[4:0];
    end
  end
  assign skip_op = op_q inside {5'h11, 5'h12, 5'h13, 5'h14, 5'h17, 5'h18};
  assign work_op = op_q inside {5'h00, 5'h01, 5'h03, 5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0D,
                                5'h0F, 5'h12, 5'h14, 5'h17};

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_plain_run;
    busy_o [*2] ##1 (!busy_o && done_o);
  endsequence
  sequence s_skip_run;
    busy_o [*3] ##1 (!busy_o && done_o);
  endsequence

  property p_plain_len;
    $rose(busy_o) && !skip_op |-> s_plain_run;
  endproperty
  property p_skip_len;
    $rose(busy_o) && skip_op |-> s_skip_run;
  endproperty
  property p_fetch;
    $rose(busy_o) |-> mem_rd_o && $stable(mem_addr_o) ##1 !mem_rd_o;
  endproperty
  property p_work_no_write;
    $rose(busy_o) && work_op |-> !mem_we_o [*4];
  endproperty
  property p_fill;
    $rose(busy_o) && op_q == OP_FAR_FILL_ONES |-> ##2 (mem_we_o && mem_wdata_o == 8'hFF);
  endproperty
  property p_rotl;
    $rose(busy_o) && op_q == OP_FAR_ROTATE_LEFT |-> ##2
      (mem_we_o && mem_wdata_o == {$past(mem_rdata_i[6:0]), $past(mem_rdata_i[7])});
  endproperty
  property p_dec_write;
    $rose(busy_o) && op_q == OP_FAR_DECREMENT_SKIP |-> ##2
      (mem_we_o && mem_wdata_o == $past(mem_rdata_i) - 8'h01) ##1
      (skip_o == ($past(mem_rdata_i, 2) == 8'h01));
  endproperty
  property p_inc_write;
    $rose(busy_o) && op_q == OP_FAR_INCREMENT_SKIP |-> ##2
      (mem_we_o && mem_wdata_o == $past(mem_rdata_i) + 8'h01);
  endproperty
  property p_nz_rewrite;
    $rose(busy_o) && op_q == OP_FAR_NONZERO_SKIP |-> ##2
      (mem_we_o && mem_wdata_o == $past(mem_rdata_i)) ##1 (skip_o == (mem_wdata_o != 8'h00));
  endproperty

  a_plain_len: assert property (p_plain_len) else $error("plain op length wrong");
  a_skip_len: assert property (p_skip_len) else $error("skip op length wrong");
  a_fetch: assert property (p_fetch) else $error("operand fetch wrong");
  a_work_no_write: assert property (p_work_no_write) else $error("memory written");
  a_fill: assert property (p_fill) else $error("fill value wrong");
  a_rotl: assert property (p_rotl) else $error("rotate left wrong");
  a_dec_write: assert property (p_dec_write) else $error("decrement skip wrong");
  a_inc_write: assert property (p_inc_write) else $error("increment skip wrong");
  a_nz_rewrite: assert property (p_nz_rewrite) else $error("nonzero skip wrong");
endmodule

bind emalu_top emalu_top_sva u_sva (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
  .mem_rdata_i(mem_rdata_i), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
  .busy_o(busy_o), .skip_o(skip_o), .done_o(done_o));

// ===== tb/emalu_mem_model.sv
// Behavioural data memory with one cycle read latency
`timescale 1ns/1ps
module emalu_mem_model
  import emalu_pkg::*;
(
  // Clock
  input  wire logic                         clk_i,
  // Access port
  input  wire logic [emalu_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                         rd_i,
  input  wire logic                         we_i,
  input  wire logic [emalu_pkg::DATA_W-1:0] wdata_i,
  output logic      [emalu_pkg::DATA_W-1:0] rdata_o
);
  import emalu_pkg::*;
  // Whole far space, no banking
  logic [DATA_W-1:0] mem_arr [0:(1<<ADDR_W)-1];

  initial rdata_o = 8'h00;
  // Outside a read slot the bus toggles so stale data is never reused
  always @(posedge clk_i) begin
    if (rd_i) begin
      rdata_o <= mem_arr[addr_i];
    end else begin
      rdata_o <= ~rdata_o;
    end
    if (we_i) begin
      mem_arr[addr_i] <= wdata_i;
    end
  end
endmodule

// ===== tb/emalu_top_tb.sv
// Self-checking bench for the far memory ALU block
`timescale 1ns/1ps
module emalu_top_tb;
  import emalu_pkg::*;
  localparam logic [ADDR_W-1:0] FAR_A = 12'hA5C;

  logic        sys_clk_i = 1'b0, nrst_i = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  logic        wb_ack_o, mem_rd_o, mem_we_o, busy_o, skip_o, done_o;
  logic [11:0] mem_addr_o;
  logic [7:0]  mem_rdata_i, mem_wdata_o;
  int          fail_count = 0, check_count = 0, cyc_cnt = 0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  emalu_top dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_rdata_i(mem_rdata_i), .mem_we_o(mem_we_o),
    .mem_wdata_o(mem_wdata_o), .busy_o(busy_o), .skip_o(skip_o), .done_o(done_o));
  emalu_mem_model u_mem (.clk_i(sys_clk_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o),
    .we_i(mem_we_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 8000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic single cycle; the slave's answer time is not assumed
  task automatic wb_rw(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                       input logic [3:0] sel, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      end_of_test();
    end
  endtask

  task automatic op_chk(input logic [4:0] op, input logic [2:0] bn, input logic [7:0] w,
    input logic [5:0] f, input logic [7:0] m, input logic [7:0] ew, input logic [5:0] ef,
    input logic [7:0] em, input logic es, input int ec);
    logic [31:0] rd;
    int n;
    n = 0;
    u_mem.mem_arr[FAR_A] = m;
    wb_rw(1'b1, ADDR_OFF, {20'h0_0000, FAR_A}, 4'h3, rd);
    wb_rw(1'b1, WORK_OFF, {24'h00_0000, w}, 4'h1, rd);
    wb_rw(1'b1, FLAGS_OFF, {26'h000_0000, f}, 4'h1, rd);
    wb_rw(1'b1, CMD_OFF, {21'h00_0000, bn, 3'h0, op}, 4'h3, rd);
    repeat (12) begin
      @(posedge sys_clk_i);
      if (busy_o === 1'b1) n++;
      else if (n > 0) break;
    end
    chk("busy cycles", n, ec);
    chk("done", {31'h0, done_o}, 32'h0000_0001);
    chk("skip pin", {31'h0, skip_o}, {31'h0, es});
    wb_rw(1'b0, WORK_OFF, 32'h0000_0000, 4'hF, rd);
    chk("work", rd, {24'h00_0000, ew});
    wb_rw(1'b0, FLAGS_OFF, 32'h0000_0000, 4'hF, rd);
    chk("flags", rd, {26'h000_0000, ef});
    wb_rw(1'b0, STATUS_OFF, 32'h0000_0000, 4'hF, rd);
    chk("status", rd, {30'h0000_0000, es, 1'b0});
    chk("memory", {24'h00_0000, u_mem.mem_arr[FAR_A]}, {24'h00_0000, em});
  endtask

  task automatic t_bus();
    logic [31:0] rd;
    wb_rw(1'b0, FLAGS_OFF, 32'h0000_0000, 4'hF, rd);
    chk("flags reset", rd, 32'h0000_0000);
    wb_rw(1'b1, ADDR_OFF, 32'h0000_0FFF, 4'h3, rd);
    wb_rw(1'b0, ADDR_OFF, 32'h0000_0000, 4'hF, rd);
    chk("full address", rd, 32'h0000_0FFF);
    wb_rw(1'b1, 8'h20, 32'h0000_00AA, 4'hF, rd);
    wb_rw(1'b0, 8'h20, 32'h0000_0000, 4'hF, rd);
    chk("unmapped", rd, 32'h0000_0000);
    wb_rw(1'b1, CMD_OFF, 32'h0000_0015, 4'h0, rd);
    repeat (2) @(posedge sys_clk_i);
    chk("no start", {31'h0, busy_o}, 32'h0000_0000);
    $display("test bus done");
  endtask

  task automatic t_move_or();
    op_chk(5'h00, 3'h0, 8'h33, 6'h3B, 8'hFF, 8'h00, 6'h3F, 8'hFF, 1'b0, 2);
    op_chk(5'h01, 3'h0, 8'h11, 6'h2A, 8'hC3, 8'hC3, 6'h2A, 8'hC3, 1'b0, 2);
    op_chk(5'h02, 3'h0, 8'h5A, 6'h15, 8'h00, 8'h5A, 6'h15, 8'h5A, 1'b0, 2);
    op_chk(5'h03, 3'h0, 8'h00, 6'h00, 8'h00, 8'h00, 6'h04, 8'h00, 1'b0, 2);
    op_chk(5'h04, 3'h0, 8'hF0, 6'h3F, 8'h0F, 8'hF0, 6'h3B, 8'hFF, 1'b0, 2);
    $display("test move or done");
  endtask

  task automatic t_rotate();
    op_chk(5'h05, 3'h0, 8'h22, 6'h00, 8'h81, 8'h22, 6'h00, 8'h03, 1'b0, 2);
    op_chk(5'h06, 3'h0, 8'h22, 6'h3E, 8'h81, 8'h03, 6'h3E, 8'h81, 1'b0, 2);
    op_chk(5'h07, 3'h0, 8'h22, 6'h00, 8'h80, 8'h22, 6'h01, 8'h00, 1'b0, 2);
    op_chk(5'h08, 3'h0, 8'h22, 6'h01, 8'h01, 8'h03, 6'h00, 8'h01, 1'b0, 2);
    op_chk(5'h09, 3'h0, 8'h22, 6'h3F, 8'h01, 8'h22, 6'h3F, 8'h80, 1'b0, 2);
    op_chk(5'h0A, 3'h0, 8'h22, 6'h00, 8'h02, 8'h01, 6'h00, 8'h02, 1'b0, 2);
    op_chk(5'h0B, 3'h0, 8'h22, 6'h00, 8'h01, 8'h22, 6'h01, 8'h00, 1'b0, 2);
    op_chk(5'h0C, 3'h0, 8'h22, 6'h01, 8'h00, 8'h80, 6'h00, 8'h00, 1'b0, 2);
    $display("test rotate done");
  endtask

  task automatic t_subtract();
    op_chk(5'h0F, 3'h0, 8'h10, 6'h00, 8'h01, 8'h0F, 6'h11, 8'h01, 1'b0, 2);
    op_chk(5'h10, 3'h0, 8'h01, 6'h00, 8'h02, 8'h01, 6'h00, 8'hFF, 1'b0, 2);
    op_chk(5'h0D, 3'h0, 8'h80, 6'h20, 8'h00, 8'h7F, 6'h09, 8'h00, 1'b0, 2);
    op_chk(5'h0E, 3'h0, 8'h04, 6'h21, 8'h04, 8'h04, 6'h37, 8'h00, 1'b0, 2);
    $display("test subtract done");
  endtask

  task automatic t_skip();
    op_chk(5'h11, 3'h0, 8'h44, 6'h3F, 8'h01, 8'h44, 6'h3F, 8'h00, 1'b1, 3);
    op_chk(5'h11, 3'h0, 8'h44, 6'h00, 8'h00, 8'h44, 6'h00, 8'hFF, 1'b0, 3);
    op_chk(5'h12, 3'h0, 8'h44, 6'h00, 8'h01, 8'h00, 6'h00, 8'h01, 1'b1, 3);
    op_chk(5'h13, 3'h0, 8'h44, 6'h15, 8'hFF, 8'h44, 6'h15, 8'h00, 1'b1, 3);
    op_chk(5'h14, 3'h0, 8'h44, 6'h00, 8'h10, 8'h11, 6'h00, 8'h10, 1'b0, 3);
    op_chk(5'h17, 3'h3, 8'h44, 6'h00, 8'h08, 8'h44, 6'h00, 8'h08, 1'b1, 3);
    op_chk(5'h17, 3'h3, 8'h44, 6'h2A, 8'hF7, 8'h44, 6'h2A, 8'hF7, 1'b0, 3);
    op_chk(5'h18, 3'h0, 8'h44, 6'h00, 8'h00, 8'h44, 6'h00, 8'h00, 1'b0, 3);
    op_chk(5'h18, 3'h0, 8'h44, 6'h00, 8'h40, 8'h44, 6'h00, 8'h40, 1'b1, 3);
    $display("test skip done");
  endtask

  task automatic t_set();
    op_chk(5'h15, 3'h0, 8'h44, 6'h2A, 8'h12, 8'h44, 6'h2A, 8'hFF, 1'b0, 2);
    op_chk(5'h16, 3'h7, 8'h44, 6'h15, 8'h00, 8'h44, 6'h15, 8'h80, 1'b0, 2);
    op_chk(5'h16, 3'h0, 8'h44, 6'h00, 8'hFE, 8'h44, 6'h00, 8'hFF, 1'b0, 2);
    $display("test set done");
  endtask

  initial begin
    repeat (8) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    t_bus();
    t_move_or();
    t_rotate();
    t_subtract();
    t_skip();
    t_set();
    end_of_test();
  end
endmodule
